// ---- imc_consts.vh ----
// imc_consts.vh: build settings, reset values and timing counts of the
// interrupt merge block.
// assumes: included by its bare name from each design file.
`ifndef IMC_CONSTS_VH
`define IMC_CONSTS_VH
`define IMC_MAX_SOURCES      32
`define IMC_NUM_INPUTS       1
`define IMC_SW_COUNT         0
`define IMC_VEC_RESET        32'h00000010
`define IMC_SENS_DEFAULT     32'hFFFFFFFF
`define IMC_LVL_DEFAULT      32'hFFFFFFFF
`define IMC_EDGE_DEFAULT     32'hFFFFFFFF
`define IMC_OUT_KIND_DEFAULT 1'h0
`define IMC_OUT_POL_DEFAULT  1'h1
`define IMC_CONN_BUS         1'h0
`define IMC_CONN_SINGLE      1'h1
`define IMC_VEC_STRIDE       32'h00000004
`define IMC_EDGE_PULSE_CYC   3'h1
`endif

// ---- imc_input_cond.v ----
// imc_input_cond.v: per-input conditioner, turns one raw request into an
// active flag.
// assumes: one clock, clock enable shared with the top module.
`timescale 1ns/1ps
`include "imc_consts.vh"

module imc_input_cond #(
  parameter SENS  = 1'b0, // 0 level, 1 edge
  parameter POL   = 1'b1, // level: 0 low 1 high; edge: 0 fall 1 rise
  parameter ASYNC = 1'b0  // 1 when the source is on another clock
) (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  input  wire ce,
  // request in, conditioned request out
  input  wire raw_in,
  output wire req
);
  reg s1_q;     // first synchroniser stage
  reg s2_q;     // second stage
  reg s3_q;     // third stage
  reg prev_q;   // previous accepted level, for edges
  wire lvl;     // accepted level of the input

  // three stage capture for unrelated sources; accepted when 2 and 3 agree
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // start at the inactive level so no false request follows reset
      s1_q   <= ~POL;
      s2_q   <= ~POL;
      s3_q   <= ~POL;
      prev_q <= ~POL;
    end else if (ce) begin
      s1_q   <= raw_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      prev_q <= lvl;
    end
  end

  // accepted level: synchronised (see R12) or direct on same clock
  assign lvl = ASYNC ? ((s2_q == s3_q) ? s3_q : prev_q) : raw_in;

  // level polarity (see R3), edge direction (see R4), kind (see R1)
  assign req = SENS ? (POL ? (lvl & ~prev_q) : (~lvl & prev_q))
                    : (POL ? lvl : ~lvl);
endmodule // imc_input_cond

// ---- imc_merge.v ----
// imc_merge.v: interrupt merge top, gathers peripheral and software
// requests into one processor request with an optional fast vector.
// assumes: one 40 MHz clock REF_CLK; enables and controls are plain ports
// from same-clock logic; peripheral inputs may be external pins.
`timescale 1ns/1ps
`include "imc_consts.vh"

// How it works
// (R1) sensitivity bit 0 level, 1 edge
// (R2) bit n of each vector governs input n
// (R3) level input: 0 active low, 1 active high
// (R4) edge input: 0 falling, 1 rising
// (R5) output kind: 0 level, 1 edge
// (R6) level output: 0 active low, 1 high
// (R7) edge output: 0 falling, 1 rising
// (R8) connection: 0 bus style, 1 single wire
// (R9) no fast mode with single wire output
// (R10) fast mode drives vector, processor acknowledges
// (R11) inputs plus software requests at most 32
// (R12) async sources synchronised before use
// (R13) options include enable, vector, pending, level registers
// (R14) defaults: one input, fast off, level omitted
// (R15) cascade enable and master default off
// (R16) master without cascade is invalid
// (R17) edge source holds inactive then active cycle
// (R18) lowest numbered active input wins
module imc_merge #(
  parameter NUM_INPUTS   = `IMC_NUM_INPUTS,     // see R14
  parameter SW_COUNT     = `IMC_SW_COUNT,
  parameter [31:0] SENS  = `IMC_SENS_DEFAULT,   // see R2
  parameter [31:0] LVLP  = `IMC_LVL_DEFAULT,
  parameter [31:0] EDGD  = `IMC_EDGE_DEFAULT,
  parameter [31:0] ASYNCV = 32'h00000000,
  parameter OUT_KIND     = `IMC_OUT_KIND_DEFAULT,
  parameter OUT_POL      = `IMC_OUT_POL_DEFAULT,
  parameter CONNECTION   = `IMC_CONN_BUS,
  parameter HAS_FAST     = 0,
  parameter HAS_SIE      = 1,
  parameter HAS_CIE      = 1,
  parameter HAS_IVR      = 1,
  parameter HAS_IPR      = 1,
  parameter HAS_ILR      = 0,
  parameter CASCADE_EN   = 0,                   // see R15
  parameter CASCADE_MST  = 0,
  parameter [31:0] VEC_RESET = `IMC_VEC_RESET
) (
  // clock, reset, enable
  input  wire        REF_CLK,
  input  wire        ARST_N,
  input  wire        CE,
  // requests in
  input  wire [31:0] INTR,
  input  wire [31:0] SW_SET,
  // control
  input  wire        MASTER_EN,
  input  wire [31:0] EN_SET,
  input  wire [31:0] EN_CLR,
  input  wire [31:0] ACK_CLR,
  input  wire [4:0]  LEVEL_LIMIT,
  input  wire        PROC_ACK,
  // status
  output reg  [31:0] PENDING,
  output reg  [31:0] ENABLED,
  output reg  [4:0]  VECTOR_ID,
  output reg         VECTOR_VALID,
  output reg  [31:0] VECTOR_ADDR,
  output reg         IRQ,
  output reg         CONFIG_ERR
);
  // sources in use: hardware inputs first, software requests above them
  localparam TOTAL = NUM_INPUTS + SW_COUNT;
  // fast mode only with bus style connection (see R9)
  localparam FAST_OK = (HAS_FAST != 0) && (CONNECTION == `IMC_CONN_BUS);
  // configuration sanity (see R11) (see R16)
  localparam BAD = (TOTAL > `IMC_MAX_SOURCES) || (TOTAL < 1) ||
                   ((CASCADE_MST != 0) && (CASCADE_EN == 0));
  // masks: every source in use, and the hardware inputs alone
  localparam [31:0] USED = (TOTAL >= 32) ? 32'hFFFFFFFF :
                           ((32'h00000001 << TOTAL) - 32'h00000001);
  localparam [31:0] HWM  = (NUM_INPUTS >= 32) ? 32'hFFFFFFFF :
                           ((32'h00000001 << NUM_INPUTS) - 32'h00000001);

  // lowest set bit index (see R18)
  function [5:0] first_set;
    input [31:0] v;
    integer k;
    begin
      first_set = 6'h20;
      for (k = 31; k >= 0; k = k - 1)
        if (v[k])
          first_set = k[5:0];
    end
  endfunction

  // internal state; the status ports copy it one cycle later
  wire [31:0] cond;      // conditioned hardware requests
  reg  [31:0] pend_q;    // sticky pending
  reg  [31:0] en_q;      // enable bits
  reg  [31:0] in_svc_q;  // acknowledged, in service (fast)
  reg  [4:0]  vid_q;
  reg         vval_q;
  reg  [31:0] vaddr_q;
  reg         irq_q;
  reg         lvl_out_q; // previous active state for edge output
  reg  [2:0]  pulse_q;   // edge output pulse counter
  reg         err_q;
  wire [31:0] pend_d;
  wire [31:0] active;
  wire [5:0]  win;
  wire        any;

  // one conditioner per peripheral input (see R1) (see R2)
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_in
      if (g < NUM_INPUTS) begin : g_used
        imc_input_cond #(
          .SENS  (SENS[g]),
          .POL   (SENS[g] ? EDGD[g] : LVLP[g]),
          .ASYNC (ASYNCV[g])
        ) u_cond (
          .clk    (REF_CLK),
          .arst_n (ARST_N),
          .ce     (CE),
          .raw_in (INTR[g]),
          .req    (cond[g])
        );
      end else begin : g_idle
        // unused inputs never request
        assign cond[g] = 1'b0;
      end
    end
  endgenerate

  // software requests sit above hardware inputs; set wins over clear;
  // pending is always kept inside, the pending option only hides it
  assign pend_d = ((pend_q & ~ACK_CLR) | cond |
                   ((SW_SET << NUM_INPUTS) & ~HWM)) & USED;
  // only enabled, not in service, master on; the level limit is checked on the winner below (see R13)
  assign active = pend_q & en_q & ~in_svc_q & {32{MASTER_EN}};
  assign win    = first_set(active);                   // see R18
  assign any    = (win != 6'h20) && !err_q &&
                  (!HAS_ILR || (win[4:0] < LEVEL_LIMIT) ||
                   (LEVEL_LIMIT == 5'h1F));

  // pending, enables, service and vector state
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_q   <= 32'h00000000;
      en_q     <= 32'h00000000;
      in_svc_q <= 32'h00000000;
      vid_q    <= 5'h00;
      vval_q   <= 1'b0;
      vaddr_q  <= VEC_RESET;
      err_q    <= 1'b0;
    end else if (CE) begin
      // configuration fault shows two edges after reset (see R16)
      err_q  <= BAD;
      pend_q <= pend_d;
      // enable set and clear ports exist as built (see R13)
      en_q <= ((en_q | (HAS_SIE ? EN_SET : 32'h00000000))
               & ~(HAS_CIE ? EN_CLR : 32'h00000000)) & USED;
      // the vector follows the winner; address steps by the stride
      if (any) begin
        vid_q   <= win[4:0];
        vaddr_q <= VEC_RESET + ({27'h0000000, win[4:0]} *
                                `IMC_VEC_STRIDE);
      end
      // valid only when the vector register is built (see R13)
      vval_q <= any && (HAS_IVR != 0);
      // fast acknowledge takes the winner into service (see R10)
      // a clear and a new service entry in one cycle: the entry wins
      if (FAST_OK && PROC_ACK && any)
        in_svc_q <= (in_svc_q & ~ACK_CLR) | (32'h00000001 << win[4:0]);
      else
        in_svc_q <= in_svc_q & ~ACK_CLR;
    end
  end

  // output request shaping (see R5) (see R6) (see R7) (see R8)
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_q     <= ~OUT_POL;
      lvl_out_q <= 1'b0;
      pulse_q   <= 3'h0;
    end else if (CE) begin
      lvl_out_q <= any;
      // level output follows the combined request
      if (OUT_KIND == 0) begin
        irq_q <= OUT_POL ? any : ~any;
      // edge output: one pulse per rise of the combined request
      end else if (any && !lvl_out_q) begin
        pulse_q <= `IMC_EDGE_PULSE_CYC;
        irq_q   <= OUT_POL;
      end else if (pulse_q > 3'h1) begin
        pulse_q <= pulse_q - 3'h1;
      end else begin
        pulse_q <= 3'h0;
        irq_q   <= ~OUT_POL;
      end
    end
  end

  // status outputs from flip-flops; vector address idles unless fast mode is allowed
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PENDING      <= 32'h00000000;
      ENABLED      <= 32'h00000000;
      VECTOR_ID    <= 5'h00;
      VECTOR_VALID <= 1'b0;
      VECTOR_ADDR  <= VEC_RESET;
      IRQ          <= ~OUT_POL;
      CONFIG_ERR   <= 1'b0;
    end else if (CE) begin
      // pending view shows only when the pending register is built
      PENDING      <= (HAS_IPR != 0) ? pend_q : 32'h00000000; // see R13
      ENABLED      <= en_q;
      VECTOR_ID    <= vid_q;
      VECTOR_VALID <= vval_q;
      VECTOR_ADDR  <= FAST_OK ? vaddr_q : VEC_RESET;        // see R9
      IRQ          <= irq_q;
      CONFIG_ERR   <= err_q;
    end
  end
endmodule // imc_merge

// ---- imc_merge_assertions.sv ----
// imc_merge_assertions.sv: port checks of the interrupt merge block.
// assumes: fast mode on, bus output, level active-high request out.
`timescale 1ns/1ps
`include "imc_consts.vh"
module imc_chk #(
  parameter SRC = 5 // inputs plus software requests
) (
  // clock and reset
  input wire        REF_CLK,
  input wire        ARST_N,
  // watched ports
  input wire        MASTER_EN,
  input wire [31:0] PENDING,
  input wire [31:0] ENABLED,
  input wire [4:0]  VECTOR_ID,
  input wire        VECTOR_VALID,
  input wire [31:0] VECTOR_ADDR,
  input wire        IRQ,
  input wire        CONFIG_ERR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // request rises together with a valid vector
  sequence s_raise;
    $rose(IRQ) ##0 VECTOR_VALID;
  endsequence
  a_vec_addr: assert property (VECTOR_VALID |->
    VECTOR_ADDR == `IMC_VEC_RESET + 32'h4 * VECTOR_ID)
    else $error("vector address off");
  a_raise_valid: assert property ($rose(IRQ) |-> s_raise)
    else $error("request without vector");
  a_cfg_legal: assert property (!CONFIG_ERR)
    else $error("legal build flagged");
  a_master_gate: assert property ((!MASTER_EN) [*4] |-> !IRQ)
    else $error("request while master off");
  a_level_hold: assert property (s_raise |=> IRQ)
    else $error("level request not held");
  a_src_limit: assert property ((PENDING >> SRC) == 32'h0)
    else $error("pending above sources");
  a_win_pend: assert property (s_raise |-> PENDING[VECTOR_ID])
    else $error("winner not pending");
  a_low_first: assert property ($rose(IRQ) && PENDING[0] &&
    ENABLED[0] && !$past(PENDING[0], 2) |-> VECTOR_ID == 5'h0)
    else $error("lowest input not first");
endmodule // imc_chk
bind imc_merge imc_chk #(
  .SRC (NUM_INPUTS + SW_COUNT)
) i_chk (
  .REF_CLK      (REF_CLK),
  .ARST_N       (ARST_N),
  .MASTER_EN    (MASTER_EN),
  .PENDING      (PENDING),
  .ENABLED      (ENABLED),
  .VECTOR_ID    (VECTOR_ID),
  .VECTOR_VALID (VECTOR_VALID),
  .VECTOR_ADDR  (VECTOR_ADDR),
  .IRQ          (IRQ),
  .CONFIG_ERR   (CONFIG_ERR)
);

// ---- imc_proc_model.sv ----
// imc_proc_model.sv: processor side, acks each fast request once.
// assumes: active-high level request, slow picks a longer wait.
`timescale 1ns/1ps
module imc_proc_model (
  // clock and reset
  input wire      clk,
  input wire      arst_n,
  // request side
  input wire      irq,
  input wire      vec_valid,
  input wire      slow,
  // acknowledge back
  output reg      ack
);
  reg [3:0] cnt_q;  // wait count
  reg       done_q; // ack already given
  // waits, then pulses ack for one cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
      ack    <= 1'b0;
    end else begin
      ack <= 1'b0;
      if (!irq) begin
        cnt_q  <= 4'h0;
        done_q <= 1'b0;
      end else if (vec_valid && !done_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == (slow ? 4'h6 : 4'h2)) begin
          ack    <= 1'b1;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // imc_proc_model

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench of the interrupt merge block.
// assumes: four inputs (0 lvl hi, 1 fall, 2 lvl lo, 3 rise), one sw.
`timescale 1ns/1ps
`include "imc_consts.vh"
module tb_top;
  localparam [31:0] IDLE = 32'h00000006; // all inputs inactive
  reg         clk = 1'b0;
  reg         arst_n = 1'b0;
  reg         mst_en = 1'b1;
  reg         slow = 1'b0;
  reg         irq_d = 1'b0;
  reg         ce = 1'b1;
  reg  [4:0]  lvl_lim = 5'h1F;
  reg  [31:0] intr = IDLE;
  reg  [31:0] sw_set = 32'h0;
  reg  [31:0] en_set = 32'h0;
  reg  [31:0] en_clr = 32'h0;
  reg  [31:0] ack_clr = 32'h0;
  wire        ack, vval, irq, cerr;
  wire [31:0] pend, enab, vaddr;
  wire [4:0]  vid;
  reg  [4:0]  exp_q[$]; // expected winners
  int         fail_count = 0;
  int         checks = 0;
  int         r;
  localparam        N_IN  = 4;            // peripheral inputs
  localparam        N_SW  = 1;            // software requests
  localparam [31:0] SENSV = 32'h0000000A; // inputs 1 and 3 on edges
  localparam [31:0] LVLV  = 32'h00000001; // input 0 high, input 2 low
  localparam [31:0] EDGV  = 32'h00000008; // input 1 falls, input 3 rises
  localparam        FAST  = 1;            // fast vector mode
  imc_merge #(.NUM_INPUTS(N_IN), .SW_COUNT(N_SW), .SENS(SENSV),
    .LVLP(LVLV), .EDGD(EDGV), .HAS_FAST(FAST)) i_dut (.REF_CLK(clk),
    .ARST_N(arst_n), .CE(ce), .INTR(intr), .SW_SET(sw_set),
    .MASTER_EN(mst_en), .EN_SET(en_set), .EN_CLR(en_clr),
    .ACK_CLR(ack_clr), .LEVEL_LIMIT(lvl_lim), .PROC_ACK(ack),
    .PENDING(pend), .ENABLED(enab), .VECTOR_ID(vid), .VECTOR_VALID(vval),
    .VECTOR_ADDR(vaddr), .IRQ(irq), .CONFIG_ERR(cerr));
  imc_proc_model i_proc (.clk(clk), .arst_n(arst_n), .irq(irq),
    .vec_valid(vval), .slow(slow), .ack(ack));
  initial forever #12.5 clk = ~clk;
  task report_and_stop;
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input [63:0] got, input [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  // bounded wait for the request level
  task wait_irq(input v);
    int n;
    n = 0;
    while (irq !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (irq !== v) begin
      chk(irq, v, "irq wait");
      report_and_stop;
    end
  endtask
  // pulse a mask for a cycle: 0 enable set, 1 enable clear, 2 ack clear
  task pulse(input [1:0] sel, input [31:0] m);
    @(negedge clk);
    case (sel)
      2'h0: en_set = m;
      2'h1: en_clr = m;
      default: ack_clr = m;
    endcase
    @(negedge clk);
    en_set = 32'h0;
    en_clr = 32'h0;
    ack_clr = 32'h0;
  endtask
  // raise sources, await request, release and clear them
  task fire(input [31:0] m, input [31:0] s, input [4:0] id);
    exp_q.push_back(id);
    @(negedge clk);
    intr = IDLE ^ m;
    sw_set = s;
    wait_irq(1'b1);
    intr = IDLE;
    sw_set = 32'h0;
    repeat (4) @(negedge clk);
    pulse(2'h2, m | (s << 4));
    chk(irq, slow | (m == 32'h9), "ack drop");
    wait_irq(1'b0);
  endtask
  // compares the winner at each rise of the request
  always @(posedge clk) begin
    irq_d <= irq;
    if (irq === 1'b1 && irq_d === 1'b0 && exp_q.size() > 0)
      chk(vid, exp_q.pop_front(), "vector id");
  end
  initial begin
    void'($urandom(74));
    r = $urandom;
    lvl_lim = r[4:0]; // no level register built, so any limit must do
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    chk(vaddr, `IMC_VEC_RESET, "reset addr");
    chk({cerr, irq, pend}, 34'h0, "reset out");
    pulse(2'h0, 32'h1F);
    @(negedge clk);
    chk(enab, 32'h1F, "enabled");
    ce = 1'b0;
    intr = IDLE ^ 32'h1;
    repeat (6) @(negedge clk);
    chk({pend, irq}, 33'h0, "frozen");
    intr = IDLE;
    ce = 1'b1;
    fire(32'h1, 32'h0, 5'd0);
    fire(32'h4, 32'h0, 5'd2);
    fire(32'h2, 32'h0, 5'd1);
    fire(32'h8, 32'h0, 5'd3);
    fire(32'h9, 32'h0, 5'd0);
    fire(32'h0, 32'h1, 5'd4);
    repeat (6) begin
      r = $urandom;
      slow = r[8];
      r = r & 3;
      fire(32'h1 << r, 32'h0, r[4:0]);
    end
    pulse(2'h1, 32'h1);
    intr = IDLE ^ 32'h1;
    repeat (10) @(negedge clk);
    chk({enab[4:0], irq}, 6'h3C, "disabled");
    intr = IDLE;
    mst_en = 1'b0;
    pulse(2'h0, 32'h1);
    intr = IDLE ^ 32'h8;
    repeat (10) @(negedge clk);
    chk({pend[3], irq}, 2'b10, "master off");
    intr = IDLE;
    pulse(2'h2, 32'h9);
    mst_en = 1'b1;
    repeat (6) @(negedge clk);
    chk({irq, exp_q.size()}, 33'h0, "left over");
    report_and_stop;
  end
endmodule // tb_top
